/* verilog/timer_extint_pkg.sv */
// constants for the timer run and external interrupt control block
// Behaviour
// (R1) a timer counts only while its run bit is 1
// (R2) timer A overflow sets the timer A overflow flag
// (R3) timer A overflow flag clears by software write or on vectoring
// (R4) ext irq B flag set by event; software clear; auto clear in edge mode
// (R5) ext irq A flag set by event; software clear; auto clear in edge mode
// (R6) ext irq B type select: 0 level sensitive, 1 edge sensitive
// (R7) ext irq B active polarity comes from its own polarity bit
// (R8) ext irq A type select 0 level, 1 edge; polarity from its bit
package timer_extint_pkg;

   localparam logic [7:0] CTRL_OFFSET   = 8'h88;
   localparam logic [7:0] CONFIG_OFFSET = 8'h8C;
   localparam logic [7:0] STATUS_OFFSET = 8'h8D;
   localparam logic [7:0] MASK_OFFSET   = 8'h8E;

   // control register fields
   localparam int CTRL_TB_RUN   = 6;
   localparam int CTRL_TA_OVF   = 5;
   localparam int CTRL_TA_RUN   = 4;
   localparam int CTRL_EB_FLAG  = 3;
   localparam int CTRL_EB_TYPE  = 2;
   localparam int CTRL_EA_FLAG  = 1;
   localparam int CTRL_EA_TYPE  = 0;

   // configuration register fields, polarity 1 = active high
   localparam int CFG_EA_POL    = 0;
   localparam int CFG_EB_POL    = 1;

   // status and mask fields
   localparam int ST_EA         = 0;
   localparam int ST_EB         = 1;
   localparam int ST_TA         = 2;
   localparam int ST_WIDTH      = 3;

   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [1:0] CONFIG_RESET = 2'h0;
   localparam logic [2:0] STATUS_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET   = 3'h0;
   localparam logic [7:0] UNMAPPED     = 8'h00;

endpackage : timer_extint_pkg

/* verilog/ext_irq_detect.sv */
// external interrupt input qualifier: polarity, level or edge
`timescale 1ns/1ps
module ext_irq_detect (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic pin,
   input  wire logic polarity,
   input  wire logic edge_mode,
   output logic      active,
   output logic      event_hit
);
   logic prev_r;

   // polarity picks which pin level counts as asserted
   assign active = polarity ? pin : ~pin; // R7 R8

   // reset to asserted so no false edge right after reset
   always_ff @(posedge clock) begin
      if (rst) begin
         prev_r <= 1'b1;
      end else begin
         prev_r <= active;
      end
   end

   assign event_hit = edge_mode ? (active & ~prev_r) : active; // R6 R8

endmodule : ext_irq_detect

/* verilog/irq_flag_cell.sv */
// one hardware set, software written, auto cleared flag
`timescale 1ns/1ps
module irq_flag_cell (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic set,
   input  wire logic wr_en,
   input  wire logic wr_val,
   input  wire logic auto_clr,
   output logic      flag
);
   logic flag_r;

   // hardware set wins over any clear in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else if (set) begin
         flag_r <= 1'b1;
      end else if (wr_en) begin
         flag_r <= wr_val;
      end else if (auto_clr) begin
         flag_r <= 1'b0;
      end
   end

   assign flag = flag_r;

endmodule : irq_flag_cell

/* verilog/timer_extint_control.sv */
// timer run control, timer A overflow flag and two external interrupts
`timescale 1ns/1ps
module timer_extint_control (
   input  wire logic       CLOCK,
   input  wire logic       RST,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       TIMER_A_OVERFLOW,
   input  wire logic       EXT_IRQ_A_INPUT,
   input  wire logic       EXT_IRQ_B_INPUT,
   input  wire logic       VECTOR_TIMER_A,
   input  wire logic       VECTOR_EXT_A,
   input  wire logic       VECTOR_EXT_B,
   output logic            TIMER_A_RUN,
   output logic            TIMER_B_RUN,
   output logic            TIMER_A_IRQ_REQ,
   output logic            EXT_IRQ_A_REQ,
   output logic            EXT_IRQ_B_REQ,
   output logic            IRQ
);

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   logic       timer_a_run_r;
   logic       timer_b_run_r;
   logic       ext_irq_a_type_select_r;
   logic       ext_irq_b_type_select_r;
   logic       ext_irq_a_polarity_r;
   logic       ext_irq_b_polarity_r;
   logic [2:0] status_r;
   logic [2:0] status_nxt;
   logic [2:0] mask_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       wr_ctrl;
   logic       wr_cfg;
   logic       wr_status;
   logic       wr_mask;
   logic       timer_a_overflow_flag;
   logic       ext_irq_a_flag;
   logic       ext_irq_b_flag;
   logic       ext_a_active;
   logic       ext_b_active;
   logic       ext_a_event;
   logic       ext_b_event;
   logic       ext_a_auto_clr;
   logic       ext_b_auto_clr;
   logic [7:0] ctrl_view;
   logic [2:0] events;

   assign wr_ctrl   = WR & hit(ADDR, timer_extint_pkg::CTRL_OFFSET);
   assign wr_cfg    = WR & hit(ADDR, timer_extint_pkg::CONFIG_OFFSET);
   assign wr_status = WR & hit(ADDR, timer_extint_pkg::STATUS_OFFSET);
   assign wr_mask   = WR & hit(ADDR, timer_extint_pkg::MASK_OFFSET);

   // run bits and type selects of the control register
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         timer_a_run_r           <= 1'b0;
         timer_b_run_r           <= 1'b0;
         ext_irq_a_type_select_r <= 1'b0;
         ext_irq_b_type_select_r <= 1'b0;
      end else if (wr_ctrl) begin
         timer_a_run_r <= WDATA[timer_extint_pkg::CTRL_TA_RUN]; // R1
         timer_b_run_r <= WDATA[timer_extint_pkg::CTRL_TB_RUN]; // R1
         ext_irq_a_type_select_r <= WDATA[timer_extint_pkg::CTRL_EA_TYPE];
         ext_irq_b_type_select_r <= WDATA[timer_extint_pkg::CTRL_EB_TYPE];
      end
   end

   // polarity bits of the configuration register
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         {ext_irq_b_polarity_r, ext_irq_a_polarity_r} <=
            timer_extint_pkg::CONFIG_RESET;
      end else if (wr_cfg) begin
         ext_irq_a_polarity_r <= WDATA[timer_extint_pkg::CFG_EA_POL]; // R8
         ext_irq_b_polarity_r <= WDATA[timer_extint_pkg::CFG_EB_POL]; // R7
      end
   end

   ext_irq_detect u_detect_a (
      .clock     (CLOCK),
      .rst       (RST),
      .pin       (EXT_IRQ_A_INPUT),
      .polarity  (ext_irq_a_polarity_r),
      .edge_mode (ext_irq_a_type_select_r),
      .active    (ext_a_active),
      .event_hit (ext_a_event)
   );

   ext_irq_detect u_detect_b (
      .clock     (CLOCK),
      .rst       (RST),
      .pin       (EXT_IRQ_B_INPUT),
      .polarity  (ext_irq_b_polarity_r),
      .edge_mode (ext_irq_b_type_select_r),
      .active    (ext_b_active),
      .event_hit (ext_b_event)
   );

   // vectoring clears an external flag only in edge mode
   assign ext_a_auto_clr = VECTOR_EXT_A & ext_irq_a_type_select_r; // R5
   assign ext_b_auto_clr = VECTOR_EXT_B & ext_irq_b_type_select_r; // R4

   irq_flag_cell u_flag_timer_a (
      .clock    (CLOCK),
      .rst      (RST),
      .set      (TIMER_A_OVERFLOW), // R2
      .wr_en    (wr_ctrl), // R3
      .wr_val   (WDATA[timer_extint_pkg::CTRL_TA_OVF]),
      .auto_clr (VECTOR_TIMER_A), // R3
      .flag     (timer_a_overflow_flag)
   );

   irq_flag_cell u_flag_ext_a (
      .clock    (CLOCK),
      .rst      (RST),
      .set      (ext_a_event), // R5
      .wr_en    (wr_ctrl),
      .wr_val   (WDATA[timer_extint_pkg::CTRL_EA_FLAG]),
      .auto_clr (ext_a_auto_clr),
      .flag     (ext_irq_a_flag)
   );

   irq_flag_cell u_flag_ext_b (
      .clock    (CLOCK),
      .rst      (RST),
      .set      (ext_b_event), // R4
      .wr_en    (wr_ctrl),
      .wr_val   (WDATA[timer_extint_pkg::CTRL_EB_FLAG]),
      .auto_clr (ext_b_auto_clr),
      .flag     (ext_irq_b_flag)
   );

   // sticky event status, write one to clear, new event wins
   always_comb begin
      events = 3'h0;
      events[timer_extint_pkg::ST_EA] = ext_a_event;
      events[timer_extint_pkg::ST_EB] = ext_b_event;
      events[timer_extint_pkg::ST_TA] = TIMER_A_OVERFLOW;
      status_nxt = status_r;
      if (wr_status) begin
         status_nxt = status_r & ~WDATA[2:0];
      end
      status_nxt = status_nxt | events;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         status_r <= timer_extint_pkg::STATUS_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         mask_r <= timer_extint_pkg::MASK_RESET;
      end else if (wr_mask) begin
         mask_r <= WDATA[2:0];
      end
   end

   // register read view, top bit reads as zero
   always_comb begin
      ctrl_view = timer_extint_pkg::CTRL_RESET;
      ctrl_view[timer_extint_pkg::CTRL_TB_RUN]  = timer_b_run_r;
      ctrl_view[timer_extint_pkg::CTRL_TA_OVF]  = timer_a_overflow_flag;
      ctrl_view[timer_extint_pkg::CTRL_TA_RUN]  = timer_a_run_r;
      ctrl_view[timer_extint_pkg::CTRL_EB_FLAG] = ext_irq_b_flag;
      ctrl_view[timer_extint_pkg::CTRL_EB_TYPE] = ext_irq_b_type_select_r;
      ctrl_view[timer_extint_pkg::CTRL_EA_FLAG] = ext_irq_a_flag;
      ctrl_view[timer_extint_pkg::CTRL_EA_TYPE] = ext_irq_a_type_select_r;
   end

   always_comb begin
      rdata_nxt = timer_extint_pkg::UNMAPPED;
      if (hit(ADDR, timer_extint_pkg::CTRL_OFFSET)) begin
         rdata_nxt = ctrl_view;
      end else if (hit(ADDR, timer_extint_pkg::CONFIG_OFFSET)) begin
         rdata_nxt = {6'h00, ext_irq_b_polarity_r, ext_irq_a_polarity_r};
      end else if (hit(ADDR, timer_extint_pkg::STATUS_OFFSET)) begin
         rdata_nxt = {5'h00, status_r};
      end else if (hit(ADDR, timer_extint_pkg::MASK_OFFSET)) begin
         rdata_nxt = {5'h00, mask_r};
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rdata_r <= timer_extint_pkg::UNMAPPED;
      end else if (RD) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= timer_extint_pkg::UNMAPPED;
      end
   end

   assign RDATA           = rdata_r;
   assign TIMER_A_RUN     = timer_a_run_r; // R1
   assign TIMER_B_RUN     = timer_b_run_r; // R1
   assign TIMER_A_IRQ_REQ = timer_a_overflow_flag; // R2
   assign EXT_IRQ_A_REQ   = ext_irq_a_flag;
   assign EXT_IRQ_B_REQ   = ext_irq_b_flag;
   assign IRQ             = |(status_r & mask_r);

   // checks
   AST_RUN_A_FOLLOWS_WRITE: assert property ( // R1
      @(posedge CLOCK) disable iff (RST)
      wr_ctrl
      |=> TIMER_A_RUN == $past(WDATA[timer_extint_pkg::CTRL_TA_RUN]))
   else $error("timer A run bit does not follow control write");

   AST_RUN_B_HOLDS: assert property ( // R1
      @(posedge CLOCK) disable iff (RST)
      !wr_ctrl |=> $stable(TIMER_B_RUN))
   else $error("timer B run bit changed without a control write");

   AST_TA_OVF_SETS: assert property ( // R2
      @(posedge CLOCK) disable iff (RST)
      TIMER_A_OVERFLOW
      |=> TIMER_A_IRQ_REQ && status_r[timer_extint_pkg::ST_TA])
   else $error("timer A overflow did not set its flag");

   AST_TA_VECTOR_CLEARS: assert property ( // R3
      @(posedge CLOCK) disable iff (RST)
      VECTOR_TIMER_A && !TIMER_A_OVERFLOW && !wr_ctrl |=> !TIMER_A_IRQ_REQ)
   else $error("timer A flag not cleared on vectoring");

   AST_TA_SW_CLEARS: assert property ( // R3
      @(posedge CLOCK) disable iff (RST)
      wr_ctrl && !WDATA[timer_extint_pkg::CTRL_TA_OVF] && !TIMER_A_OVERFLOW
      |=> !TIMER_A_IRQ_REQ)
   else $error("timer A flag not cleared by software");

   AST_EB_EVENT_SETS: assert property ( // R4
      @(posedge CLOCK) disable iff (RST)
      ext_b_event
      |=> EXT_IRQ_B_REQ [*1] ##0 status_r[timer_extint_pkg::ST_EB])
   else $error("ext irq B event did not set its flag");

   AST_EB_LEVEL_NO_AUTOCLR: assert property ( // R4
      @(posedge CLOCK) disable iff (RST)
      VECTOR_EXT_B && !ext_irq_b_type_select_r && EXT_IRQ_B_REQ && !wr_ctrl
      |=> EXT_IRQ_B_REQ)
   else $error("ext irq B flag cleared on vectoring in level mode");

   AST_EA_EDGE_AUTOCLR: assert property ( // R5
      @(posedge CLOCK) disable iff (RST)
      VECTOR_EXT_A && ext_irq_a_type_select_r && !ext_a_event && !wr_ctrl
      |=> !EXT_IRQ_A_REQ)
   else $error("ext irq A flag not cleared on vectoring in edge mode");

   AST_EA_EVENT_SETS: assert property ( // R5
      @(posedge CLOCK) disable iff (RST)
      ext_a_event |=> EXT_IRQ_A_REQ)
   else $error("ext irq A event did not set its flag");

   AST_EB_EDGE_ONE_SHOT: assert property ( // R6
      @(posedge CLOCK) disable iff (RST)
      ext_irq_b_type_select_r && ext_b_active && $past(ext_b_active)
      && $stable(ext_irq_b_type_select_r) && $stable(ext_irq_b_polarity_r)
      |-> !ext_b_event)
   else $error("ext irq B edge mode fired on a held level");

   AST_EB_LEVEL_SETS: assert property ( // R6
      @(posedge CLOCK) disable iff (RST)
      !ext_irq_b_type_select_r && ext_b_active |=> EXT_IRQ_B_REQ)
   else $error("ext irq B level mode did not set its flag");

   AST_EB_POLARITY: assert property ( // R7
      @(posedge CLOCK) disable iff (RST)
      !ext_irq_b_type_select_r && ext_irq_b_polarity_r == EXT_IRQ_B_INPUT
      |=> EXT_IRQ_B_REQ)
   else $error("ext irq B polarity not honoured");

   AST_EA_POLARITY_LEVEL: assert property ( // R8
      @(posedge CLOCK) disable iff (RST)
      !ext_irq_a_type_select_r && ext_irq_a_polarity_r == EXT_IRQ_A_INPUT
      |=> EXT_IRQ_A_REQ)
   else $error("ext irq A level mode or polarity not honoured");

   AST_EA_IDLE_QUIET: assert property ( // R8
      @(posedge CLOCK) disable iff (RST)
      ext_irq_a_polarity_r != EXT_IRQ_A_INPUT |-> !ext_a_event)
   else $error("ext irq A fired while its input was inactive");

   AST_RUN_B_FOLLOWS_WRITE: assert property ( // R1
      @(posedge CLOCK) disable iff (RST)
      wr_ctrl
      |=> TIMER_B_RUN == $past(WDATA[timer_extint_pkg::CTRL_TB_RUN]))
   else $error("timer B run bit does not follow control write");

   AST_RUN_A_HOLDS: assert property ( // R1
      @(posedge CLOCK) disable iff (RST)
      !wr_ctrl |=> $stable(TIMER_A_RUN))
   else $error("timer A run bit changed without a control write");

   AST_TA_SW_SETS: assert property ( // R3
      @(posedge CLOCK) disable iff (RST)
      wr_ctrl && WDATA[timer_extint_pkg::CTRL_TA_OVF] |=> TIMER_A_IRQ_REQ)
   else $error("timer A flag not set by a software write of one");

   AST_TA_NO_SPURIOUS: assert property ( // R2
      @(posedge CLOCK) disable iff (RST)
      !TIMER_A_OVERFLOW && !wr_ctrl && !TIMER_A_IRQ_REQ
      |=> !TIMER_A_IRQ_REQ)
   else $error("timer A flag rose without an overflow or a write");

   AST_TA_STATUS_CLEAR: assert property ( // R2
      @(posedge CLOCK) disable iff (RST)
      wr_status && WDATA[timer_extint_pkg::ST_TA] && !TIMER_A_OVERFLOW
      |=> !status_r[timer_extint_pkg::ST_TA])
   else $error("timer A status bit not cleared by a write of one");

   AST_EB_EDGE_AUTOCLR: assert property ( // R4
      @(posedge CLOCK) disable iff (RST)
      VECTOR_EXT_B && ext_irq_b_type_select_r && !ext_b_event && !wr_ctrl
      |=> !EXT_IRQ_B_REQ)
   else $error("ext irq B flag not cleared on vectoring in edge mode");

   AST_EA_LEVEL_NO_AUTOCLR: assert property ( // R5
      @(posedge CLOCK) disable iff (RST)
      VECTOR_EXT_A && !ext_irq_a_type_select_r && EXT_IRQ_A_REQ && !wr_ctrl
      |=> EXT_IRQ_A_REQ)
   else $error("ext irq A flag cleared on vectoring in level mode");

   AST_EA_EDGE_ONE_SHOT: assert property ( // R8
      @(posedge CLOCK) disable iff (RST)
      ext_irq_a_type_select_r && ext_a_active && $past(ext_a_active)
      |-> !ext_a_event)
   else $error("ext irq A edge mode fired on a held level");

   AST_EB_IDLE_QUIET: assert property ( // R7
      @(posedge CLOCK) disable iff (RST)
      ext_irq_b_polarity_r != EXT_IRQ_B_INPUT |-> !ext_b_event)
   else $error("ext irq B fired while its input was inactive");

endmodule : timer_extint_control

/* verif/core_vector_model.sv */
// core model that vectors to pending timer and ext irq routines
`timescale 1ns/1ps
module core_vector_model (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic auto_en,
   input  wire logic req_ta,
   input  wire logic req_a,
   input  wire logic req_b,
   output logic      vec_ta,
   output logic      vec_a,
   output logic      vec_b
);
   // a vector pulse on alternate cycles while a request stays pending and the core takes interrupts
   always_ff @(posedge clock) begin
      if (rst) begin
         vec_ta <= 1'b0;
         vec_a  <= 1'b0;
         vec_b  <= 1'b0;
      end else begin
         vec_ta <= auto_en & req_ta & ~vec_ta;
         vec_a  <= auto_en & req_a & ~vec_a;
         vec_b  <= auto_en & req_b & ~vec_b;
      end
   end
endmodule : core_vector_model

/* verif/testbench.sv */
// self-checking bench for the timer and ext irq control block
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] A_CTL = timer_extint_pkg::CTRL_OFFSET;
   localparam logic [7:0] A_CFG = timer_extint_pkg::CONFIG_OFFSET;
   localparam logic [7:0] A_ST  = timer_extint_pkg::STATUS_OFFSET;
   localparam logic [7:0] A_MSK = timer_extint_pkg::MASK_OFFSET;
   logic       CLOCK, RST, WR, RD, OVF, PIN_A, PIN_B, AUTO;
   logic       VEC_TA, VEC_A, VEC_B, RUN_A, RUN_B, REQ_TA, REQ_A, REQ_B;
   logic       IRQ;
   logic [7:0] ADDR, WDATA, RDATA;
   int         n_fail, checked;

   timer_extint_control uut (
      .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .TIMER_A_OVERFLOW(OVF),
      .EXT_IRQ_A_INPUT(PIN_A), .EXT_IRQ_B_INPUT(PIN_B),
      .VECTOR_TIMER_A(VEC_TA), .VECTOR_EXT_A(VEC_A), .VECTOR_EXT_B(VEC_B),
      .TIMER_A_RUN(RUN_A), .TIMER_B_RUN(RUN_B), .TIMER_A_IRQ_REQ(REQ_TA),
      .EXT_IRQ_A_REQ(REQ_A), .EXT_IRQ_B_REQ(REQ_B), .IRQ(IRQ));

   core_vector_model core (
      .clock(CLOCK), .rst(RST), .auto_en(AUTO), .req_ta(REQ_TA),
      .req_a(REQ_A), .req_b(REQ_B), .vec_ta(VEC_TA), .vec_a(VEC_A),
      .vec_b(VEC_B));

   always #2.5 CLOCK = ~CLOCK;

   task cyc(input int n);
      repeat (n) @(posedge CLOCK);
   endtask : cyc

   task check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLOCK);
      WR    <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLOCK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLOCK);
      RD   <= 1'b0;
      #1 check(RDATA, exp);
   endtask : rd

   task t_regs;
      rd(A_CTL, 8'h00);
      rd(A_CFG, 8'h00);
      rd(A_ST, 8'h00);
      rd(A_MSK, 8'h00);
      rd(8'h90, 8'h00);
      wr(A_CTL, 8'hC0);
      #1 check({6'h00, RUN_B, RUN_A}, 8'h02);
      rd(A_CTL, 8'h40);
      wr(A_CTL, 8'h10);
      #1 check({6'h00, RUN_B, RUN_A}, 8'h01);
      wr(8'h90, 8'hFF);
      rd(A_CTL, 8'h10);
      wr(A_CTL, 8'h00);
      #1 check({6'h00, RUN_B, RUN_A}, 8'h00);
      $display("test regs done");
   endtask : t_regs

   task ovf_pulse;
      @(posedge CLOCK);
      OVF <= 1'b1;
      @(posedge CLOCK);
      OVF <= 1'b0;
      cyc(1);
   endtask : ovf_pulse

   task t_timer;
      ovf_pulse();
      #1 check({7'h00, REQ_TA}, 8'h01);
      rd(A_CTL, 8'h20);
      rd(A_ST, 8'h04);
      wr(A_CTL, 8'h00);
      #1 check({7'h00, REQ_TA}, 8'h00);
      ovf_pulse();
      AUTO <= 1'b1;
      cyc(4);
      #1 check({7'h00, REQ_TA}, 8'h00);
      AUTO <= 1'b0;
      wr(A_ST, 8'h04);
      rd(A_ST, 8'h00);
      $display("test timer done");
   endtask : t_timer

   task t_race;
      wr(A_CTL, 8'h20);
      #1 check({7'h00, REQ_TA}, 8'h01);
      @(posedge CLOCK);
      ADDR  <= A_CTL;
      WDATA <= 8'h00;
      WR    <= 1'b1;
      OVF   <= 1'b1;
      @(posedge CLOCK);
      WR  <= 1'b0;
      OVF <= 1'b0;
      #1 check({7'h00, REQ_TA}, 8'h01);
      wr(A_CTL, 8'h00);
      wr(A_ST, 8'h04);
      #1 check({7'h00, REQ_TA}, 8'h00);
      $display("test race done");
   endtask : t_race

   task t_ext_a;
      wr(A_CFG, 8'h01);
      PIN_A <= 1'b0;
      wr(A_CTL, 8'h01);
      wr(A_ST, 8'h07);
      rd(A_CTL, 8'h01);
      wr(A_MSK, 8'h01);
      PIN_A <= 1'b1;
      cyc(3);
      #1 check({6'h00, IRQ, REQ_A}, 8'h03);
      wr(A_MSK, 8'h00);
      #1 check({7'h00, IRQ}, 8'h00);
      wr(A_MSK, 8'h01);
      #1 check({7'h00, IRQ}, 8'h01);
      wr(A_ST, 8'h01);
      #1 check({7'h00, IRQ}, 8'h00);
      AUTO <= 1'b1;
      cyc(4);
      #1 check({7'h00, REQ_A}, 8'h00);
      AUTO <= 1'b0;
      cyc(3);
      #1 check({7'h00, REQ_A}, 8'h00);
      wr(A_CTL, 8'h00);
      cyc(2);
      #1 check({7'h00, REQ_A}, 8'h01);
      @(posedge CLOCK);
      PIN_A <= 1'b0;
      AUTO  <= 1'b1;
      cyc(4);
      #1 check({7'h00, REQ_A}, 8'h01);
      AUTO <= 1'b0;
      wr(A_CTL, 8'h00);
      wr(A_MSK, 8'h00);
      wr(A_ST, 8'h07);
      rd(A_CTL, 8'h00);
      $display("test ext a done");
   endtask : t_ext_a

   task t_ext_b;
      wr(A_CTL, 8'h04);
      PIN_B <= 1'b0;
      cyc(3);
      #1 check({7'h00, REQ_B}, 8'h01);
      rd(A_ST, 8'h02);
      AUTO <= 1'b1;
      cyc(4);
      #1 check({7'h00, REQ_B}, 8'h00);
      AUTO <= 1'b0;
      wr(A_CTL, 8'h04);
      PIN_B <= 1'b1;
      cyc(3);
      #1 check({7'h00, REQ_B}, 8'h00);
      wr(A_CTL, 8'h00);
      cyc(2);
      #1 check({7'h00, REQ_B}, 8'h00);
      @(posedge CLOCK);
      PIN_B <= 1'b0;
      cyc(2);
      #1 check({7'h00, REQ_B}, 8'h01);
      @(posedge CLOCK);
      PIN_B <= 1'b1;
      AUTO  <= 1'b1;
      cyc(4);
      #1 check({7'h00, REQ_B}, 8'h01);
      AUTO <= 1'b0;
      wr(A_CTL, 8'h00);
      #1 check({7'h00, REQ_B}, 8'h00);
      wr(A_CFG, 8'h03);
      cyc(2);
      #1 check({7'h00, REQ_B}, 8'h01);
      $display("test ext b done");
   endtask : t_ext_b

   task wrap_up;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      CLOCK = 1'b0;
      RST   = 1'b1;
      {WR, RD, OVF, AUTO, ADDR, WDATA} = '0;
      PIN_A = 1'b1;
      PIN_B = 1'b1;
      n_fail  = 0;
      checked = 0;
      cyc(8);
      RST <= 1'b0;
      t_regs();
      t_timer();
      t_race();
      t_ext_a();
      t_ext_b();
      wrap_up();
   end

   initial begin
      #20000;
      n_fail++;
      wrap_up();
   end
endmodule : testbench
